// ==== core/serial_port_defines.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz clock, plain register port with word addresses
// Notes:   included by the serial port core and its package users
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

`define CLK_HZ            25000000
`define MS_PER_S          1000
`define CYC_PER_MS        (`CLK_HZ / `MS_PER_S)

// register word addresses
`define REG_CTRL          8'h00
`define REG_RTS_ON        8'h01
`define REG_RTS_OFF       8'h02
`define REG_MIN_DELAY     8'h03
`define REG_NODE_ADDR     8'h04
`define REG_TX_DATA       8'h05
`define REG_RX_DATA       8'h06
`define REG_STATUS        8'h07
`define REG_SBO_CFG       8'h08
`define REG_SBO_SEL_TIME  8'h09
`define REG_POINT_CNT0    8'h0A
`define REG_POINT_CNT1    8'h0B
`define REG_ERR_PTR       8'h0C
`define REG_BP_LIMIT      8'h0D
`define REG_BP_EVENT      8'h0E
`define REG_SBO_CMD       8'h0F

// control fields
`define CTRL_EN           0
`define CTRL_CTS_EN       1
`define CTRL_STOP2        2
`define CTRL_PAR_LO       3
`define CTRL_DBITS_LO     5
`define CTRL_BAUD_LO      8
`define CTRL_RESET        32'h0000_0360

// limits and node address reset value
`define AI_MAX            16'h012C
`define WORD_MAX          16'h0032
`define SEL_MAX           16'h7FFF
`define CHASSIS_MAX       3'h6
`define NODE_RESET        8'h01

`endif

// ==== core/serial_port_modem_control.sv ====
// Purpose: serial port with modem control and link configuration
// Assumes: 25 MHz clock, synchronous active-high reset
// Notes:   one character buffered each way; software polls status
//
// How it works
// [RULE_01] port idle unless enable bit set
// [RULE_02] twelve selectable line rates
// [RULE_03] none, odd or even parity
// [RULE_04] five to eight data bits
// [RULE_05] one or two stop bits
// [RULE_06] rts lead delay before first bit
// [RULE_07] rts hold after last byte
// [RULE_08] minimum delay before any response
// [RULE_09] cts gates sending when monitored
// [RULE_10] integrator enables cts for two-wire modems
// [RULE_11] node address 0 to 255
// [RULE_12] activation time equals duration times unit
// [RULE_13] selection valid for set milliseconds
// [RULE_14] one selection time for all ports
// [RULE_15] analog point count 0 to 300
// [RULE_16] digital word count 0 to 50
// [RULE_17] accumulator count 0 to 50
// [RULE_18] indication word count 0 to 50
// [RULE_19] error block pointer register
// [RULE_20] chassis index 0 to 6
// [RULE_21] backplane error limit stops ports
// [RULE_22] start, lsb first, parity, high stops
// [RULE_23] no new send before rts release
//
// Our own choices: the address map and the address-and-strobe port.
`include "serial_port_defines.svh"
`timescale 1ns/1ns
module serial_port_modem_control
  import serial_port_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        rxd,
  input  wire logic        cts,
  output logic             txd,
  output logic             rts,
  output logic             ports_off,
  output logic             select_valid,
  output logic             activation_on
);

  function automatic logic [15:0] clip(input logic [15:0] v,
                                       input logic [15:0] lim);
    clip = (v > lim) ? lim : v;
  endfunction : clip

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [15:0] rts_on_ff, nxt_rts_on, rts_off_ff, nxt_rts_off;
  logic [15:0] min_dly_ff, nxt_min_dly;
  logic [7:0]  node_ff, nxt_node;
  logic [17:0] sbo_cfg_ff, nxt_sbo_cfg;
  logic [15:0] sel_time_ff, nxt_sel_time;
  logic [31:0] cnt0_ff, nxt_cnt0, cnt1_ff, nxt_cnt1;
  logic [15:0] err_ptr_ff, nxt_err_ptr;
  logic [15:0] bp_lim_ff, nxt_bp_lim, bp_err_ff, nxt_bp_err;
  logic        off_ff, nxt_off;
  logic [7:0]  txbuf_ff, nxt_txbuf;
  logic        txfull_ff, nxt_txfull;
  logic [7:0]  rxbuf_ff, nxt_rxbuf;
  logic        rxfull_ff, nxt_rxfull, rxerr_ff, nxt_rxerr;
  logic        sbo_go;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        tx_take, rx_done, rx_bad;
  logic [7:0]  rx_word;

  logic        port_on;
  logic [1:0]  parity_sel;
  logic [1:0]  dbits_sel;
  logic [3:0]  baud_sel;
  assign port_on    = ctrl_ff[`CTRL_EN] & ~off_ff; // RULE_01
  assign parity_sel = ctrl_ff[`CTRL_PAR_LO +: 2];
  assign dbits_sel  = ctrl_ff[`CTRL_DBITS_LO +: 2];
  assign baud_sel   = ctrl_ff[`CTRL_BAUD_LO +: 4];

  logic [15:0] acc_lim, ind_lim;
  logic [2:0]  chs_lim;
  assign acc_lim = clip({8'h00, wdata[7:0]}, `WORD_MAX);
  assign ind_lim = clip({8'h00, wdata[15:8]}, `WORD_MAX);
  assign chs_lim = (wdata[18:16] > `CHASSIS_MAX) ? `CHASSIS_MAX
                                                 : wdata[18:16];

  always_comb begin
    nxt_ctrl = ctrl_ff; nxt_rts_on = rts_on_ff; nxt_rts_off = rts_off_ff;
    nxt_min_dly = min_dly_ff; nxt_node = node_ff; nxt_sbo_cfg = sbo_cfg_ff;
    nxt_sel_time = sel_time_ff; nxt_cnt0 = cnt0_ff; nxt_cnt1 = cnt1_ff;
    nxt_err_ptr = err_ptr_ff; nxt_bp_lim = bp_lim_ff; nxt_bp_err = bp_err_ff;
    nxt_off = off_ff; nxt_txbuf = txbuf_ff; nxt_txfull = txfull_ff;
    nxt_rxbuf = rxbuf_ff; nxt_rxfull = rxfull_ff; nxt_rxerr = rxerr_ff;
    nxt_rdata = 32'h0000_0000;
    sbo_go = 1'b0;
    if (tx_take) nxt_txfull = 1'b0;
    if (rd) begin
      case (addr)
        `REG_CTRL:         nxt_rdata = ctrl_ff;
        `REG_RTS_ON:       nxt_rdata = {16'h0000, rts_on_ff};
        `REG_RTS_OFF:      nxt_rdata = {16'h0000, rts_off_ff};
        `REG_MIN_DELAY:    nxt_rdata = {16'h0000, min_dly_ff};
        `REG_NODE_ADDR:    nxt_rdata = {24'h000000, node_ff}; // RULE_11
        `REG_RX_DATA:      nxt_rdata = {24'h000000, rxbuf_ff};
        `REG_STATUS:       nxt_rdata = {26'h0, select_valid, activation_on,
                                        off_ff, rxerr_ff, rxfull_ff,
                                        txfull_ff};
        `REG_SBO_CFG:      nxt_rdata = {14'h0, sbo_cfg_ff};
        `REG_SBO_SEL_TIME: nxt_rdata = {16'h0000, sel_time_ff}; // RULE_14
        `REG_POINT_CNT0:   nxt_rdata = cnt0_ff;
        `REG_POINT_CNT1:   nxt_rdata = cnt1_ff;
        `REG_ERR_PTR:      nxt_rdata = {16'h0000, err_ptr_ff}; // RULE_19
        `REG_BP_LIMIT:     nxt_rdata = {bp_err_ff, bp_lim_ff};
        default:           nxt_rdata = 32'h0000_0000;
      endcase
      if (addr == `REG_RX_DATA) begin
        nxt_rxfull = 1'b0;
        nxt_rxerr  = 1'b0;
      end
    end
    if (wr) begin
      case (addr)
        `REG_CTRL:         nxt_ctrl = {20'h0, wdata[11:0]};
        `REG_RTS_ON:       nxt_rts_on = wdata[15:0];
        `REG_RTS_OFF:      nxt_rts_off = wdata[15:0];
        `REG_MIN_DELAY:    nxt_min_dly = wdata[15:0];
        `REG_NODE_ADDR:    nxt_node = wdata[7:0];
        `REG_TX_DATA: begin
          nxt_txbuf  = wdata[7:0];
          nxt_txfull = 1'b1;
        end
        `REG_SBO_CFG:      nxt_sbo_cfg = wdata[17:0];
        `REG_SBO_SEL_TIME: nxt_sel_time = clip(wdata[15:0], `SEL_MAX); // RULE_13
        `REG_POINT_CNT0:   nxt_cnt0 = {clip(wdata[31:16], `WORD_MAX),
                                       clip(wdata[15:0], `AI_MAX)}; // RULE_15 RULE_16
        `REG_POINT_CNT1:   nxt_cnt1 = {13'h0, chs_lim, ind_lim[7:0],
                                       acc_lim[7:0]}; // RULE_17 RULE_18 RULE_20
        `REG_ERR_PTR:      nxt_err_ptr = wdata[15:0];
        `REG_BP_LIMIT: begin
          nxt_bp_lim = wdata[15:0];
          nxt_bp_err = 16'h0000;
          nxt_off    = 1'b0;
        end
        `REG_BP_EVENT: begin
          if (wdata[0]) nxt_bp_err = 16'h0000;
          else if (bp_err_ff != 16'hFFFF) nxt_bp_err = bp_err_ff + 16'h0001;
        end
        `REG_SBO_CMD:      sbo_go = 1'b1;
        default: ;
      endcase
    end
    // a limit write restarts the count, so it overrides the stale compare
    if (!(wr && addr == `REG_BP_LIMIT) && bp_lim_ff != 16'h0000 &&
        bp_err_ff >= bp_lim_ff) nxt_off = 1'b1; // RULE_21
    if (rx_done) begin // receive event wins over read clear
      nxt_rxbuf  = rx_word;
      nxt_rxfull = 1'b1;
      nxt_rxerr  = rx_bad;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_ff <= `CTRL_RESET; rts_on_ff <= 16'h0000; rts_off_ff <= 16'h0000;
      min_dly_ff <= 16'h0000; node_ff <= `NODE_RESET; sbo_cfg_ff <= 18'h0;
      sel_time_ff <= 16'h0000; cnt0_ff <= 32'h0; cnt1_ff <= 32'h0;
      err_ptr_ff <= 16'h0000; bp_lim_ff <= 16'h0000; bp_err_ff <= 16'h0000;
      off_ff <= 1'b0; txbuf_ff <= 8'h00; txfull_ff <= 1'b0;
      rxbuf_ff <= 8'h00; rxfull_ff <= 1'b0; rxerr_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ctrl_ff <= nxt_ctrl; rts_on_ff <= nxt_rts_on; rts_off_ff <= nxt_rts_off;
      min_dly_ff <= nxt_min_dly; node_ff <= nxt_node; sbo_cfg_ff <= nxt_sbo_cfg;
      sel_time_ff <= nxt_sel_time; cnt0_ff <= nxt_cnt0; cnt1_ff <= nxt_cnt1;
      err_ptr_ff <= nxt_err_ptr; bp_lim_ff <= nxt_bp_lim; bp_err_ff <= nxt_bp_err;
      off_ff <= nxt_off; txbuf_ff <= nxt_txbuf; txfull_ff <= nxt_txfull;
      rxbuf_ff <= nxt_rxbuf; rxfull_ff <= nxt_rxfull; rxerr_ff <= nxt_rxerr;
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata = rdata_ff;

  // ----------------------------------------------------------------
  // millisecond tick and bit timing
  // ----------------------------------------------------------------
  logic [14:0] ms_ff, nxt_ms;
  logic        ms_tick;
  logic [17:0] bdiv_ff, nxt_bdiv;
  logic        bit_tick;
  logic [17:0] bit_cycles;
  always_comb begin
    case (baud_sel) // RULE_02: clock / rate
      4'h0: bit_cycles = 18'h377C9;
      4'h1: bit_cycles = 18'h28B0B;
      4'h2: bit_cycles = 18'h14585;
      4'h3: bit_cycles = 18'h0A2C3;
      4'h4: bit_cycles = 18'h05161;
      4'h5: bit_cycles = 18'h028B1;
      4'h6: bit_cycles = 18'h01458;
      4'h7: bit_cycles = 18'h00A2C;
      4'h8: bit_cycles = 18'h00516;
      4'h9: bit_cycles = 18'h00364;
      4'hA: bit_cycles = 18'h001B2;
      default: bit_cycles = 18'h000D9;
    endcase
  end
  assign ms_tick  = (ms_ff == 15'(`CYC_PER_MS - 1));
  assign bit_tick = (bdiv_ff == 18'h0);
  always_comb begin
    nxt_ms = ms_tick ? 15'h0 : ms_ff + 15'h1;
  end
  always_ff @(posedge clock) begin
    if (rst) ms_ff <= 15'h0;
    else     ms_ff <= nxt_ms;
  end

  // ----------------------------------------------------------------
  // transmitter with modem control
  // ----------------------------------------------------------------
  logic [2:0]  rsync_ff, csync_ff;
  logic        cts_ok;
  always_ff @(posedge clock) begin
    if (rst) begin
      rsync_ff <= 3'b111;
      csync_ff <= 3'b000;
    end else begin
      rsync_ff <= {rsync_ff[1:0], rxd};
      csync_ff <= {csync_ff[1:0], cts};
    end
  end
  logic cts_lvl_ff;
  always_ff @(posedge clock) begin
    if (rst) cts_lvl_ff <= 1'b0;
    else if (csync_ff[2] == csync_ff[1]) cts_lvl_ff <= csync_ff[2];
  end
  assign cts_ok = ~ctrl_ff[`CTRL_CTS_EN] | cts_lvl_ff; // RULE_09

  tx_state_t   tst_ff, nxt_tst;
  bit_phase_t  ph_ff, nxt_ph;
  logic [15:0] msc_ff, nxt_msc;
  logic [16:0] gap_ff, nxt_gap;
  logic [14:0] tms_ff, nxt_tms;
  logic        tms_tick;
  logic [2:0]  bi_ff, nxt_bi;
  logic [7:0]  sh_ff, nxt_sh;
  logic        par_ff, nxt_par, txd_ff, nxt_txd, rts_ff, nxt_rts;
  logic        stop2_ff, nxt_stop2;
  logic [2:0]  last_bit;
  assign last_bit = 3'(dbits_sel + 2'd0) + 3'h4; // 5..8 bits
  // own ms prescaler, restarted on each rts delay so none runs short
  assign tms_tick = (tms_ff == 15'(`CYC_PER_MS - 1));

  always_comb begin
    nxt_tst = tst_ff; nxt_ph = ph_ff; nxt_msc = msc_ff; nxt_bi = bi_ff;
    nxt_sh = sh_ff; nxt_par = par_ff; nxt_txd = txd_ff; nxt_rts = rts_ff;
    nxt_stop2 = stop2_ff; tx_take = 1'b0;
    nxt_tms = tms_tick ? 15'h0 : tms_ff + 15'h1;
    nxt_gap = (gap_ff != 17'h0 && ms_tick) ? gap_ff - 17'h1 : gap_ff;
    nxt_bdiv = bit_tick ? bit_cycles - 18'h1 : bdiv_ff - 18'h1;
    case (tst_ff)
      TX_IDLE: begin
        nxt_txd = 1'b1;
        nxt_rts = 1'b0; // RULE_23
        if (port_on && txfull_ff && gap_ff == 17'h0) begin // RULE_08
          nxt_rts = 1'b1;
          nxt_tms = 15'h0;
          nxt_msc = rts_on_ff;
          nxt_tst = TX_RTS_ON;
        end
      end
      TX_RTS_ON: begin // RULE_06
        if (msc_ff == 16'h0) begin
          if (cts_ok) begin
            nxt_tst = TX_SEND; nxt_ph = BIT_START;
            nxt_bdiv = 18'h0;
          end
        end else if (tms_tick) nxt_msc = msc_ff - 16'h1;
      end
      TX_SEND: if (bit_tick) begin
        case (ph_ff) // RULE_22
          BIT_START: begin
            if (!txfull_ff || !cts_ok || !port_on) begin
              nxt_tst = TX_RTS_OFF; nxt_msc = rts_off_ff; // RULE_07
              nxt_tms = 15'h0;
            end else begin
              tx_take = 1'b1; nxt_txd = 1'b0; nxt_sh = txbuf_ff;
              nxt_par = (parity_sel == PAR_ODD); nxt_bi = 3'h0;
              nxt_stop2 = ctrl_ff[`CTRL_STOP2]; nxt_ph = BIT_DATA;
            end
          end
          BIT_DATA: begin
            nxt_txd = sh_ff[0]; nxt_sh = sh_ff >> 1;
            nxt_par = par_ff ^ sh_ff[0]; nxt_bi = bi_ff + 3'h1;
            if (bi_ff == last_bit)
              nxt_ph = (parity_sel == PAR_NONE) ? BIT_STOP : BIT_PAR; // RULE_03
            else nxt_ph = BIT_DATA; // RULE_04
          end
          BIT_PAR: begin
            nxt_txd = par_ff; nxt_ph = BIT_STOP; nxt_bi = 3'h0;
          end
          BIT_STOP: begin
            nxt_txd = 1'b1;
            nxt_stop2 = 1'b0;
            if (!stop2_ff) nxt_ph = BIT_START; // RULE_05
          end
          default: nxt_ph = BIT_START;
        endcase
      end
      TX_RTS_OFF: begin
        if (msc_ff == 16'h0) begin
          nxt_rts = 1'b0; nxt_tst = TX_IDLE;
        end else if (tms_tick) nxt_msc = msc_ff - 16'h1;
      end
      default: nxt_tst = TX_IDLE;
    endcase
    // one extra tick so the gap is never shorter than set
    if (rx_done)
      nxt_gap = (min_dly_ff == 16'h0) ? 17'h0 : {1'b0, min_dly_ff} + 17'h1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tst_ff <= TX_IDLE; ph_ff <= BIT_START; msc_ff <= 16'h0;
      gap_ff <= 17'h0; bi_ff <= 3'h0; sh_ff <= 8'h00; par_ff <= 1'b0;
      txd_ff <= 1'b1; rts_ff <= 1'b0; stop2_ff <= 1'b0; bdiv_ff <= 18'h0;
      tms_ff <= 15'h0;
    end else begin
      tst_ff <= nxt_tst; ph_ff <= nxt_ph; msc_ff <= nxt_msc;
      gap_ff <= nxt_gap; bi_ff <= nxt_bi; sh_ff <= nxt_sh; par_ff <= nxt_par;
      txd_ff <= nxt_txd; rts_ff <= nxt_rts; stop2_ff <= nxt_stop2;
      bdiv_ff <= nxt_bdiv;
      tms_ff <= nxt_tms;
    end
  end
  assign txd = txd_ff;
  assign rts = rts_ff;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  rx_state_t   rst_ff, nxt_rst;
  logic [18:0] rcnt_ff, nxt_rcnt;
  logic [2:0]  rbi_ff, nxt_rbi;
  logic [7:0]  rsh_ff, nxt_rsh;
  logic        rpar_ff, nxt_rpar, rin;
  assign rin = rsync_ff[2];
  always_comb begin
    nxt_rst = rst_ff; nxt_rbi = rbi_ff; nxt_rsh = rsh_ff; nxt_rpar = rpar_ff;
    nxt_rcnt = (rcnt_ff != 19'h0) ? rcnt_ff - 19'h1 : 19'h0;
    rx_done = 1'b0; rx_bad = 1'b0; rx_word = rsh_ff >> (3'h7 - last_bit);
    case (rst_ff)
      RX_IDLE: if (port_on && !rin && rsync_ff[1] == rin) begin // RULE_01
        nxt_rcnt = 19'(bit_cycles) + 19'(bit_cycles >> 1);
        nxt_rst = RX_DATA; nxt_rbi = 3'h0;
        nxt_rpar = (parity_sel == PAR_ODD);
      end
      RX_DATA: if (rcnt_ff == 19'h0) begin
        nxt_rsh = {rin, rsh_ff[7:1]}; nxt_rpar = rpar_ff ^ rin;
        nxt_rbi = rbi_ff + 3'h1; nxt_rcnt = 19'(bit_cycles);
        if (rbi_ff == last_bit)
          nxt_rst = (parity_sel == PAR_NONE) ? RX_STOP : RX_PAR;
      end
      RX_PAR: if (rcnt_ff == 19'h0) begin
        nxt_rpar = rpar_ff ^ rin; nxt_rcnt = 19'(bit_cycles);
        nxt_rst = RX_STOP;
      end
      RX_STOP: if (rcnt_ff == 19'h0) begin
        rx_done = 1'b1;
        rx_bad  = ~rin | (parity_sel != PAR_NONE && rpar_ff);
        nxt_rst = RX_IDLE;
      end
      default: nxt_rst = RX_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      rst_ff <= RX_IDLE; rcnt_ff <= 19'h0; rbi_ff <= 3'h0;
      rsh_ff <= 8'h00; rpar_ff <= 1'b0;
    end else begin
      rst_ff <= nxt_rst; rcnt_ff <= nxt_rcnt; rbi_ff <= nxt_rbi;
      rsh_ff <= nxt_rsh; rpar_ff <= nxt_rpar;
    end
  end

  // ----------------------------------------------------------------
  // select-before-operate timers
  // ----------------------------------------------------------------
  logic [15:0] selc_ff, nxt_selc;
  logic [31:0] actc_ff, nxt_actc;
  logic        sv_ff, nxt_sv, ao_ff, nxt_ao;
  logic [15:0] unit_ms;
  always_comb begin
    case (sbo_cfg_ff[17:16]) // RULE_12
      2'h0:    unit_ms = 16'h000A;
      2'h1:    unit_ms = 16'h0064;
      2'h2:    unit_ms = 16'h03E8;
      default: unit_ms = 16'h2710;
    endcase
    nxt_selc = selc_ff; nxt_sv = sv_ff; nxt_actc = actc_ff; nxt_ao = ao_ff;
    if (sbo_go) begin
      nxt_selc = sel_time_ff; nxt_sv = 1'b1; // RULE_13
      nxt_actc = sbo_cfg_ff[15:0] * unit_ms; // RULE_12
      nxt_ao = (sbo_cfg_ff[15:0] != 16'h0);
    end else if (ms_tick) begin
      if (selc_ff != 16'h0) nxt_selc = selc_ff - 16'h1;
      else nxt_sv = 1'b0;
      if (actc_ff > 32'h1) nxt_actc = actc_ff - 32'h1;
      else begin
        nxt_actc = 32'h0; nxt_ao = 1'b0;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      selc_ff <= 16'h0; actc_ff <= 32'h0; sv_ff <= 1'b0; ao_ff <= 1'b0;
    end else begin
      selc_ff <= nxt_selc; actc_ff <= nxt_actc; sv_ff <= nxt_sv;
      ao_ff <= nxt_ao;
    end
  end
  assign select_valid  = sv_ff;
  assign activation_on = ao_ff;
  assign ports_off     = off_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_idle_no_tx: assert property (@(posedge clock) disable iff (rst)
    (tst_ff == TX_IDLE) |=> txd) else $error("txd low while idle"); // RULE_01
  chk_rts_before_tx: assert property (@(posedge clock) disable iff (rst)
    $fell(txd) |-> rts) else $error("start bit without rts"); // RULE_06
  chk_cts_gate: assert property (@(posedge clock) disable iff (rst)
    (tst_ff == TX_RTS_ON && !cts_ok) |=> tst_ff != TX_SEND)
    else $error("send began without cts"); // RULE_09
  chk_rts_drop: assert property (@(posedge clock) disable iff (rst)
    (tst_ff == TX_RTS_OFF && msc_ff == 16'h0) |=> !rts)
    else $error("rts not released"); // RULE_07
  chk_no_restart: assert property (@(posedge clock) disable iff (rst)
    (tst_ff == TX_RTS_OFF) |=> tst_ff != TX_RTS_ON)
    else $error("restart before release"); // RULE_23
  chk_gap_hold: assert property (@(posedge clock) disable iff (rst)
    (gap_ff != 17'h0 && tst_ff == TX_IDLE) |=> !rts)
    else $error("response inside minimum delay"); // RULE_08
  chk_sel_limit: assert property (@(posedge clock) disable iff (rst)
    sel_time_ff <= `SEL_MAX) else $error("selection time over range"); // RULE_13
  chk_port_off: assert property (@(posedge clock) disable iff (rst)
    (!(wr && addr == `REG_BP_LIMIT) && bp_lim_ff != 16'h0 &&
     bp_err_ff >= bp_lim_ff) |=> ports_off)
    else $error("ports not shut down"); // RULE_21
  cov_send: cover property (@(posedge clock) disable iff (rst) $fell(txd));
  cov_rx: cover property (@(posedge clock) disable iff (rst) rx_done);
  cov_sbo: cover property (@(posedge clock) disable iff (rst) $rose(sv_ff));

endmodule : serial_port_modem_control

// ==== core/serial_port_pkg.sv ====
// Purpose: types shared by the serial port core
// Assumes: nothing
// Notes:   constants live in serial_port_defines.svh
package serial_port_pkg;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_RSV} parity_t;
  typedef enum logic [2:0] {
    TX_IDLE, TX_RTS_ON, TX_SEND, TX_RTS_OFF
  } tx_state_t;
  typedef enum logic [2:0] {
    BIT_START, BIT_DATA, BIT_PAR, BIT_STOP
  } bit_phase_t;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : serial_port_pkg

// ==== test/far_master.sv ====
// Purpose: remote serial master on the far side of the port
// Assumes: fixed bit time in clock cycles, same rate as the port
// Notes:   rxd idles high; cts starts low and is raised by the bench
`timescale 1ns/1ns
module far_master #(parameter int BIT = 217) (
  input  wire logic clock,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts
);
  initial rxd = 1'b1;
  initial cts = 1'b0;
  task automatic put(input logic b);
    rxd <= b;
    repeat (BIT) @(posedge clock);
  endtask : put
  // start, lsb first, parity, high stops at the shared rate
  task automatic send(input logic [7:0] d, input int n, p, s);
    put(1'b0);
    for (int i = 0; i < n; i++) put(d[i]);
    if (p != 0) put(^d ^ (p == 1));
    repeat (s) put(1'b1);
  endtask : send
  task automatic get(input int n, p, s, output logic [7:0] d,
                     output logic ok);
    int k;
    d = 8'h00;
    for (k = 0; k < 60000 && txd !== 1'b0; k++) @(posedge clock);
    repeat (BIT / 2) @(posedge clock);
    ok = (txd === 1'b0) && (k < 60000);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clock);
      d[i] = txd;
    end
    if (p != 0) begin
      repeat (BIT) @(posedge clock);
      ok &= (txd === (^d ^ (p == 1)));
    end
    repeat (s) begin
      repeat (BIT) @(posedge clock);
      ok &= (txd === 1'b1);
    end
  endtask : get
endmodule : far_master

// ==== test/tb.sv ====
// Purpose: self-checking bench for the serial port core
// Assumes: fastest line rate, ms delays set to 0 or 1
// Notes:   the far master decodes and sends frames
`include "serial_port_defines.svh"
`timescale 1ns/1ns
module tb;
  import serial_port_pkg::*;
  localparam int MS = `CYC_PER_MS;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        rxd, cts, txd, rts, ports_off, select_valid, activation_on;
  logic [7:0]  d;
  logic        ok;
  int          errors = 0;
  int          n_checks = 0;
  int          t, bad;

  always #20 clock = ~clock;

  serial_port_modem_control u_dut(.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .cts(cts),
    .txd(txd), .rts(rts), .ports_off(ports_off),
    .select_valid(select_valid), .activation_on(activation_on));
  far_master u_far(.clock(clock), .txd(txd), .rxd(rxd), .cts(cts));

  task automatic check(input string w, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task automatic wrap_up();
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 check($sformatf("reg %h", a), rdata, e);
  endtask : rchk
  function automatic logic [31:0] cfg(int n, p, s, c);
    return 32'h0000_0B01 | 32'(c << 1) | 32'((s - 1) << 2)
         | 32'(p << 3) | 32'((n - 5) << 5);
  endfunction : cfg
  // one character each way with the given framing
  task automatic frame(input int n, p, s, input logic [7:0] v);
    wreg(`REG_CTRL, cfg(n, p, s, 0));
    wreg(`REG_TX_DATA, {24'h0, v});
    u_far.get(n, p, s, d, ok);
    check("tx frame", {23'h0, ok, d}, {24'h1, v});
    u_far.send(v, n, p, s);
    rchk(`REG_STATUS, 32'h2);
    rchk(`REG_RX_DATA, {24'h0, v});
  endtask : frame

  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rchk(`REG_CTRL, `CTRL_RESET);
    rchk(`REG_NODE_ADDR, 32'h1);
    rchk(8'h20, 32'h0);
    wreg(`REG_NODE_ADDR, 32'hFF);
    rchk(`REG_NODE_ADDR, 32'hFF);
    wreg(`REG_SBO_SEL_TIME, 32'hFFFF);
    rchk(`REG_SBO_SEL_TIME, 32'h7FFF);
    wreg(`REG_POINT_CNT0, 32'hFFFF_FFFF);
    rchk(`REG_POINT_CNT0, 32'h0032_012C);
    wreg(`REG_POINT_CNT1, 32'h0007_FFFF);
    rchk(`REG_POINT_CNT1, 32'h0006_3232);
    wreg(`REG_ERR_PTR, 32'h1234);
    rchk(`REG_ERR_PTR, 32'h1234);
    wreg(`REG_BP_LIMIT, 32'h2);
    wreg(`REG_BP_EVENT, 32'h0);
    wreg(`REG_BP_EVENT, 32'h0);
    repeat (2) @(posedge clock);
    check("off", 32'(ports_off), 32'h1);
    rchk(`REG_BP_LIMIT, 32'h0002_0002);
    wreg(`REG_BP_LIMIT, 32'h0);
    wreg(`REG_BP_EVENT, 32'h0);
    repeat (2) @(posedge clock);
    check("off", 32'(ports_off), 32'h0);
    wreg(`REG_RTS_ON, 32'h0);
    wreg(`REG_RTS_OFF, 32'h0);
    wreg(`REG_MIN_DELAY, 32'h0);
    wreg(`REG_CTRL, 32'h0000_0B60);
    wreg(`REG_TX_DATA, 32'h55);
    bad = 0;
    repeat (600) @(posedge clock) bad += (txd !== 1'b1 || rts !== 1'b0);
    check("idle", bad, 0);
    for (int i = 0; i < 4; i++)
      frame(5+i, i%3, 1+i%2, 8'hB3 & (8'hFF >> (3-i)));
    // cts monitored and low: nothing may leave
    wreg(`REG_CTRL, cfg(8, 0, 1, 1));
    wreg(`REG_TX_DATA, 32'h3C);
    bad = 0;
    repeat (1000) @(posedge clock) bad += (txd !== 1'b1);
    check("cts hold", bad, 0);
    u_far.cts <= 1'b1;
    u_far.get(8, 0, 1, d, ok);
    check("cts frame", {ok, d}, 9'h13C);
    for (t = 0; t < 400 && rts !== 1'b0; t++) @(posedge clock);
    // selection window 1 ms, activation 1 x 10 ms
    wreg(`REG_SBO_SEL_TIME, 32'h1);
    wreg(`REG_SBO_CFG, 32'h0_0001);
    wreg(`REG_SBO_CMD, 32'h0);
    rchk(`REG_STATUS, 32'h30);
    wreg(`REG_RTS_ON, 32'h1);
    wreg(`REG_RTS_OFF, 32'h1);
    wreg(`REG_TX_DATA, 32'hA6);
    for (t = 0; t < 100 && rts !== 1'b1; t++) @(posedge clock);
    for (t = 0; t < 2 * MS && txd !== 1'b0; t++) @(posedge clock);
    check("lead", t >= MS && t < MS + 20, 1);
    u_far.get(8, 0, 1, d, ok);
    check("lead frame", {ok, d}, 9'h1A6);
    // second message queued after the first ended, rts still held
    wreg(`REG_RTS_ON, 32'h0);
    repeat (200) @(posedge clock);
    wreg(`REG_TX_DATA, 32'h5A);
    bad = 0;
    for (t = 0; t < 2 * MS && rts !== 1'b0; t++) begin
      @(posedge clock);
      bad += (txd !== 1'b1);
    end
    // stop bit ended 96 cycles before the loop began
    check("hold", t + 96 >= MS && t + 96 < MS + 20, 1);
    check("gap", bad, 0);
    u_far.get(8, 0, 1, d, ok);
    check("next", {ok, d}, 9'h15A);
    check("select", 32'(select_valid), 32'h0);
    check("activation", 32'(activation_on), 32'h1);
    wrap_up();
  end
endmodule : tb
